// ===== ivam_consts.vh
`ifndef IVAM_CONSTS_VH
`define IVAM_CONSTS_VH
// ----------------------------------------
// Vector map
// ----------------------------------------
`define IVAM_RESET_PC 24'h000000
`define IVAM_IVT_BASE 24'h000004
`define IVAM_ALT_OFS 24'h000100
`define IVAM_NTRAP 8
`define IVAM_NUSER 87
`define IVAM_ALT_BIT 15
`define IVAM_TRAP_LVL 4'h8
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IVAM_CTRL2_OFS 12'h000
`define IVAM_TRAP_OFS 12'h004
`define IVAM_LATCH_OFS 12'h008
`define IVAM_FLAG_OFS 12'h040
`define IVAM_EN_OFS 12'h060
`define IVAM_PRIO_OFS 12'h080
`define IVAM_VTAB_OFS 12'h400
`define IVAM_VTAB_ALT_BIT 9
// ----------------------------------------
// Decode kinds and responses
// ----------------------------------------
`define IVAM_K_NONE 3'h0
`define IVAM_K_CTRL 3'h1
`define IVAM_K_TRAP 3'h2
`define IVAM_K_LATCH 3'h3
`define IVAM_K_FLAG 3'h4
`define IVAM_K_EN 3'h5
`define IVAM_K_PRIO 3'h6
`define IVAM_K_VTAB 3'h7
`define IVAM_RESP_OKAY 2'h0
`define IVAM_RESP_SLVERR 2'h2
`endif

// ===== ivam_top.v
// Behaviour
// - Select bit routes all vectors alternate
// - Alternate address equals default plus 0x100
// - Reset clears state, start address zero
// - Traps 0-7 at 0x04 upward, step two
// - User vector n at 0x14+2n, packed bits
// - Each vector holds 24-bit handler address
// - Equal level: lower vector wins
// - Flags set by hardware, software clears
`timescale 1ns/1ps
`include "ivam_consts.vh"
module ivam_top #(
  parameter NTRAP = `IVAM_NTRAP,
  parameter NUSER = `IVAM_NUSER
) (
  // Clock, reset, enable
  input wire CLK,
  input wire ARST_N,
  input wire CE,
  // Request sources
  input wire [NUSER-1:0] IRQ_REQ,
  input wire [NTRAP-1:0] TRAP_REQ,
  // CPU side
  input wire [2:0] CPU_IPL,
  input wire VEC_ACK,
  output wire VEC_VALID,
  output wire [6:0] VEC_NUM,
  output wire [3:0] VEC_LVL,
  output wire [23:0] VEC_ADDR,
  output wire [23:0] HANDLER_ADDR,
  output wire [23:0] RESET_PC,
  output wire INT,
  // AXI4-Lite slave
  input wire [11:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [11:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY
);
  localparam NV = NTRAP + NUSER;
  localparam NT = 2 * NV;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [2:0] kind;
    input [11:0] a;
    begin
      kind = `IVAM_K_NONE;
      if (a == `IVAM_CTRL2_OFS) kind = `IVAM_K_CTRL;
      else if (a == `IVAM_TRAP_OFS) kind = `IVAM_K_TRAP;
      else if (a == `IVAM_LATCH_OFS) kind = `IVAM_K_LATCH;
      else if (a[11:5] == `IVAM_FLAG_OFS >> 5 && a[4:2] * 16 < NUSER && a[1:0] == 2'h0)
        kind = `IVAM_K_FLAG;
      else if (a[11:5] == `IVAM_EN_OFS >> 5 && a[4:2] * 16 < NUSER && a[1:0] == 2'h0)
        kind = `IVAM_K_EN;
      else if (a[11:7] == `IVAM_PRIO_OFS >> 7 && a[6:2] * 4 < NUSER && a[1:0] == 2'h0)
        kind = `IVAM_K_PRIO;
      else if (a[11:10] == `IVAM_VTAB_OFS >> 10 && a[8:2] < NV && a[1:0] == 2'h0)
        kind = `IVAM_K_VTAB;
    end
  endfunction

  function [31:0] smask;
    input [3:0] s;
    begin
      smask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg alt;
  reg [NTRAP-1:0] trap;
  reg [NUSER-1:0] flag;
  reg [NUSER-1:0] en;
  reg [2:0] prio [0:NUSER-1];
  reg [23:0] vtab [0:NT-1];
  reg [7:0] latch_num;
  reg [3:0] latch_lvl;
  reg aw_full;
  reg w_full;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] rd_val;
  // One loop index per process, so no process retriggers another
  integer i_arb;
  integer i_clr;
  integer i_seq;
  integer i_rd;

  wire do_wr = aw_full & w_full & ~BVALID;
  wire [2:0] wkind = kind(aw_addr);
  wire [31:0] wm = smask(w_strb);
  wire [31:0] wclr = w_data & wm;

  assign AWREADY = CE & ~aw_full & ~BVALID;
  assign WREADY = CE & ~w_full & ~BVALID;
  assign ARREADY = CE & ~RVALID;

  // ----------------------------------------
  // Arbitration and vector address
  // ----------------------------------------
  reg [2:0] best_lvl;
  reg [6:0] best_n;
  reg [6:0] trap_n;
  reg [NUSER-1:0] flag_clr;
  reg [NTRAP-1:0] trap_clr;

  always @* begin
    best_lvl = 3'h0;
    best_n = 7'h00;
    trap_n = 7'h00;
    for (i_arb = 0; i_arb < NUSER; i_arb = i_arb + 1) begin
      if (flag[i_arb] && en[i_arb] && prio[i_arb] > best_lvl) begin
        best_lvl = prio[i_arb];
        best_n = i_arb[6:0];
      end
    end
    for (i_arb = NTRAP - 1; i_arb >= 0; i_arb = i_arb - 1) begin
      if (trap[i_arb]) begin
        trap_n = i_arb[6:0];
      end
    end
  end

  wire trap_hit = |trap;
  // Level zero never wins, so it never raises VEC_VALID, though it still raises INT
  assign VEC_VALID = trap_hit | (best_lvl > CPU_IPL);
  assign VEC_NUM = trap_hit ? trap_n : best_n + NTRAP[6:0];
  assign VEC_LVL = trap_hit ? `IVAM_TRAP_LVL : {1'b0, best_lvl};
  assign VEC_ADDR = (alt ? `IVAM_ALT_OFS : 24'h000000) + `IVAM_IVT_BASE
    + {16'h0000, VEC_NUM, 1'b0};
  assign HANDLER_ADDR = vtab[(alt ? NV : 0) + VEC_NUM];
  assign RESET_PC = `IVAM_RESET_PC;
  assign INT = |(flag & en) | trap_hit;

  // ----------------------------------------
  // Write-one-to-clear decode
  // ----------------------------------------
  always @* begin
    flag_clr = {NUSER{1'b0}};
    trap_clr = {NTRAP{1'b0}};
    if (do_wr && wkind == `IVAM_K_FLAG) begin
      for (i_clr = 0; i_clr < NUSER; i_clr = i_clr + 1) begin
        if (i_clr / 16 == aw_addr[4:2]) flag_clr[i_clr] = wclr[i_clr % 16];
      end
    end
    if (do_wr && wkind == `IVAM_K_TRAP) trap_clr = wclr[NTRAP-1:0];
  end

  // ----------------------------------------
  // Clocked state
  // ----------------------------------------
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alt <= 1'b0;
      trap <= {NTRAP{1'b0}};
      flag <= {NUSER{1'b0}};
      en <= {NUSER{1'b0}};
      for (i_seq = 0; i_seq < NUSER; i_seq = i_seq + 1) prio[i_seq] <= 3'h0;
      for (i_seq = 0; i_seq < NT; i_seq = i_seq + 1) vtab[i_seq] <= 24'h000000;
      latch_num <= 8'h00;
      latch_lvl <= 4'h0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `IVAM_RESP_OKAY;
      RVALID <= 1'b0;
      RRESP <= `IVAM_RESP_OKAY;
      RDATA <= 32'h00000000;
    end else if (CE) begin
      flag <= (flag & ~flag_clr) | IRQ_REQ;
      trap <= (trap & ~trap_clr) | TRAP_REQ;
      if (VEC_ACK && VEC_VALID) begin
        latch_num <= {trap_hit, VEC_NUM};
        latch_lvl <= VEC_LVL;
      end
      if (AWVALID && AWREADY) begin
        aw_full <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_full <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (wkind == `IVAM_K_NONE) ? `IVAM_RESP_SLVERR : `IVAM_RESP_OKAY;
        case (wkind)
          `IVAM_K_CTRL: begin
            if (w_strb[1]) alt <= w_data[`IVAM_ALT_BIT];
          end
          `IVAM_K_EN: begin
            for (i_seq = 0; i_seq < NUSER; i_seq = i_seq + 1) begin
              if (i_seq / 16 == aw_addr[4:2] && wm[i_seq % 16])
                en[i_seq] <= w_data[i_seq % 16];
            end
          end
          `IVAM_K_PRIO: begin
            for (i_seq = 0; i_seq < NUSER; i_seq = i_seq + 1) begin
              if (i_seq / 4 == aw_addr[6:2] && wm[(i_seq % 4) * 4])
                prio[i_seq] <= w_data[(i_seq % 4) * 4 +: 3];
            end
          end
          `IVAM_K_VTAB: begin
            for (i_seq = 0; i_seq < 24; i_seq = i_seq + 1) begin
              if (wm[i_seq])
                vtab[(aw_addr[`IVAM_VTAB_ALT_BIT] ? NV : 0) + aw_addr[8:2]][i_seq] <= w_data[i_seq];
            end
          end
          default: begin
          end
        endcase
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= rd_val;
        RRESP <= (kind(ARADDR) == `IVAM_K_NONE) ? `IVAM_RESP_SLVERR : `IVAM_RESP_OKAY;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rd_val = 32'h00000000;
    case (kind(ARADDR))
      `IVAM_K_CTRL: rd_val[`IVAM_ALT_BIT] = alt;
      `IVAM_K_TRAP: rd_val[NTRAP-1:0] = trap;
      `IVAM_K_LATCH: rd_val = {20'h00000, latch_lvl, latch_num};
      `IVAM_K_FLAG: begin
        for (i_rd = 0; i_rd < NUSER; i_rd = i_rd + 1) begin
          if (i_rd / 16 == ARADDR[4:2]) rd_val[i_rd % 16] = flag[i_rd];
        end
      end
      `IVAM_K_EN: begin
        for (i_rd = 0; i_rd < NUSER; i_rd = i_rd + 1) begin
          if (i_rd / 16 == ARADDR[4:2]) rd_val[i_rd % 16] = en[i_rd];
        end
      end
      `IVAM_K_PRIO: begin
        for (i_rd = 0; i_rd < NUSER; i_rd = i_rd + 1) begin
          if (i_rd / 4 == ARADDR[6:2]) rd_val[(i_rd % 4) * 4 +: 3] = prio[i_rd];
        end
      end
      `IVAM_K_VTAB: rd_val[23:0] = vtab[(ARADDR[`IVAM_VTAB_ALT_BIT] ? NV : 0) + ARADDR[8:2]];
      default: rd_val = 32'h00000000;
    endcase
  end
endmodule // ivam_top

// ===== ivam_properties.sv
`timescale 1ns/1ps
// ------
// Vector and bus checks
// ------
module ivam_props #(parameter NTRAP = 8) (
  // Clock, reset, enable
  input wire CLK,
  input wire ARST_N,
  input wire CE,
  // Requests and vector side
  input wire [NTRAP-1:0] TRAP_REQ,
  input wire VEC_VALID,
  input wire INT,
  input wire [6:0] VEC_NUM,
  input wire [3:0] VEC_LVL,
  input wire [23:0] VEC_ADDR,
  input wire [23:0] RESET_PC,
  // Bus answers
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA,
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_vec_map: assert property (
    VEC_ADDR == {15'h0, VEC_ADDR[8], 8'h04} + {16'h0, VEC_NUM, 1'h0}) else $error("bad map");
  a_reset_pc: assert property (
    RESET_PC == 24'h000000) else $error("bad reset pc");
  a_trap_lvl: assert property (
    VEC_VALID && VEC_NUM < 7'h08 |-> VEC_LVL == 4'h8) else $error("bad trap level");
  a_trap_int: assert property (
    CE && |TRAP_REQ |=> INT && VEC_VALID && VEC_NUM < 7'h08) else $error("trap lost");
  a_trap_first: assert property (
    CE && TRAP_REQ[0] |=> VEC_NUM == 7'h00) else $error("trap order");
  a_rd_answer: assert property (
    ARVALID && ARREADY |=> RVALID) else $error("read late");
  a_rd_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read dropped");
  a_wr_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("response dropped");
endmodule // ivam_props
bind ivam_top ivam_props #(.NTRAP(NTRAP)) ivam_props_inst (.CLK, .ARST_N, .CE, .TRAP_REQ,
  .VEC_VALID, .INT, .VEC_NUM, .VEC_LVL, .VEC_ADDR, .RESET_PC, .ARVALID, .ARREADY,
  .RVALID, .RREADY, .RDATA, .BVALID, .BREADY, .BRESP);

// ===== ivam_cpu.sv
`timescale 1ns/1ps
// ------
// CPU core taking vectors
// ------
module ivam_cpu (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Vector offer
  input wire vec_valid,
  input wire [3:0] lat,
  output reg vec_ack
);
  reg [3:0] cnt;
  // fetch after lat cycles, slow or prompt
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_ack <= 1'h0;
      cnt <= 4'h0;
    end else begin
      vec_ack <= vec_valid && cnt == lat && !vec_ack;
      cnt <= (vec_valid && cnt != lat) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // ivam_cpu

// ===== tb_interrupt_vector_address_map.sv
`timescale 1ns/1ps
// ------
// Bench
// ------
module tb_interrupt_vector_address_map;
  reg CLK = 1'h0, ARST_N = 1'h0, CE = 1'h1, AWVALID = 1'h0, WVALID = 1'h0;
  reg BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0, bd, rv;
  reg [86:0] IRQ_REQ = 87'h0;
  reg [7:0] TRAP_REQ = 8'h0;
  reg [2:0] CPU_IPL = 3'h0;
  reg [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
  reg [31:0] WDATA = 32'h0, s = 32'h1C58FA7A, d;
  reg [3:0] WSTRB = 4'hF, lat = 4'h0, lv;
  reg [1:0] br, rr;
  reg [6:0] n, m;
  reg [23:0] h;
  integer err_total = 0, num_checks = 0, t, k;
  wire VEC_ACK, VEC_VALID, INT, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire [6:0] VEC_NUM;
  wire [3:0] VEC_LVL;
  wire [23:0] VEC_ADDR, HANDLER_ADDR, RESET_PC;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  ivam_top ivam_top_inst (.CLK, .ARST_N, .CE, .IRQ_REQ, .TRAP_REQ, .CPU_IPL, .VEC_ACK,
    .VEC_VALID, .VEC_NUM, .VEC_LVL, .VEC_ADDR, .HANDLER_ADDR, .RESET_PC, .INT, .AWADDR,
    .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  ivam_cpu ivam_cpu_inst (.clk(CLK), .arst_n(ARST_N), .vec_valid(VEC_VALID), .lat(lat),
    .vec_ack(VEC_ACK));
  always #12.5 CLK = ~CLK;
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [23:0] va(input [6:0] i, input alt);
    va = 24'h4 + {16'h0, i, 1'h0} + {15'h0, alt, 8'h0};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Ready raised late on purpose so the slave must hold its answer
  task wr(input [11:0] a, input [31:0] v);
    begin
      bd = 1'h0;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      for (k = 0; k < 64 && !bd; k = k + 1) begin
        @(posedge CLK);
        if (AWVALID && AWREADY) AWVALID <= 1'h0;
        if (WVALID && WREADY) WVALID <= 1'h0;
        if (BVALID && BREADY) begin
          bd = 1'h1;
          br = BRESP;
          BREADY <= 1'h0;
        end else if (BVALID) BREADY <= 1'h1;
      end
      if (!bd) err_total = err_total + 1;
    end
  endtask
  task rd(input [11:0] a);
    begin
      rv = 1'h0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'h1;
      for (k = 0; k < 64 && !rv; k = k + 1) begin
        @(posedge CLK);
        if (ARVALID && ARREADY) ARVALID <= 1'h0;
        if (RVALID && RREADY) begin
          rv = 1'h1;
          d = RDATA;
          rr = RRESP;
          RREADY <= 1'h0;
        end else if (RVALID) RREADY <= 1'h1;
      end
      if (!rv) err_total = err_total + 1;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #(25 * 20000);
    err_total = err_total + 1;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1'h1;
    @(negedge CLK) chk("pc", 32'h0, {8'h0, RESET_PC});
    chk("idle", 32'h14, {6'h0, VEC_VALID, INT, VEC_ADDR});
    wr(12'hFFC, 32'hFFFFFFFF);
    rd(12'hFFC);
    chk("resp", 32'h22, {26'h0, br, 2'h0, rr});
    $display("reset test done");
    for (t = 0; t < 8; t = t + 1) begin
      @(posedge CLK) TRAP_REQ <= 8'h01 << t;
      @(posedge CLK) TRAP_REQ <= 8'h00;
      @(negedge CLK) chk("trap", {8'h8, va(t[6:0], 1'h0)}, {4'h0, VEC_LVL, VEC_ADDR});
      wr(12'h004, 32'h1 << t);
    end
    chk("tclr", 32'h0, {31'h0, INT});
    $display("trap test done");
    // Corner vectors first and last, then random ones
    for (t = 0; t < 6; t = t + 1) begin
      s = nx(s);
      n = (t == 0) ? 7'h00 : (t == 1) ? 7'h56 : 7'(s % 32'h57);
      m = n + 7'h08;
      lv = {1'h0, s[6:4] % 3'h7} + 4'h1;
      h = s[31:8];
      lat <= {2'h0, s[1:0]};
      wr(12'h080 + {n[6:2], 2'h0}, {28'h0, lv} << {n[1:0], 2'h0});
      wr(12'h400 + {m, 2'h0}, {8'h0, h});
      wr(12'h600 + {m, 2'h0}, {8'h0, ~h});
      @(posedge CLK) IRQ_REQ <= 87'h1 << n;
      @(posedge CLK) IRQ_REQ <= 87'h0;
      @(negedge CLK) chk("mask", 32'h0, {31'h0, INT});
      wr(12'h060 + {n[6:4], 2'h0}, 32'h1 << n[3:0]);
      chk("user", {4'h0, lv, va(m, 1'h0)}, {4'h0, VEC_LVL, VEC_ADDR});
      chk("hdl", {8'h0, h}, {8'h0, HANDLER_ADDR});
      CPU_IPL <= lv[2:0];
      @(negedge CLK) chk("ipl", 32'h1, {30'h0, VEC_VALID, INT});
      @(posedge CLK) CPU_IPL <= 3'h0;
      wr(12'h000, 32'h8000);
      chk("alt", {8'h0, va(m, 1'h1)}, {8'h0, VEC_ADDR});
      chk("ahdl", {8'h0, ~h}, {8'h0, HANDLER_ADDR});
      wr(12'h000, 32'h0);
      rd(12'h008);
      chk("ack", {20'h0, lv, 1'h0, m}, d);
      wr(12'h040 + {n[6:4], 2'h0}, 32'h1 << n[3:0]);
      chk("clr", 32'h0, {31'h0, INT});
      wr(12'h060 + {n[6:4], 2'h0}, 32'h0);
    end
    $display("user test done");
    wr(12'h080, 32'h4000);
    wr(12'h084, 32'h0040);
    wr(12'h060, 32'h0028);
    @(posedge CLK) IRQ_REQ <= 87'h28;
    @(posedge CLK) IRQ_REQ <= 87'h0;
    @(negedge CLK) chk("tie", 32'h0B, {25'h0, VEC_NUM});
    wr(12'h040, 32'h8);
    chk("next", 32'h0D, {25'h0, VEC_NUM});
    $display("tie test done");
    chk("pre", 32'h1, {31'h0, INT});
    @(posedge CLK) ARST_N <= 1'h0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'h1;
    @(negedge CLK) chk("rst", 32'h14, {6'h0, VEC_VALID, INT, VEC_ADDR});
    rd(12'h060);
    chk("rsten", 32'h0, d);
    // Request pulse while frozen must leave no flag behind
    @(posedge CLK) CE <= 1'h0;
    IRQ_REQ <= 87'h1;
    @(posedge CLK) IRQ_REQ <= 87'h0;
    CE <= 1'h1;
    rd(12'h040);
    chk("frz", 32'h0, d);
    $display("reset and freeze test done");
    end_of_test;
  end
endmodule // tb_interrupt_vector_address_map
